/* File: rtl/fsq_cfg.svh */
// Behaviour
// R1: Supply lockout or overvoltage stops switching, auto-resumes
// R2: Soft start minimum peak, full drive after 1.6ms
// R3: Output at 80 percent enters soft landing
// R4: Feedback at maximum for 160ms raises overload
// R5: Overload shutdown resumes when fault is gone
// R6: Valley detector turns switch on in discontinuous mode
// R7: Below 90 percent load frequency folds back
// R8: Burst stop at stop level, restart at restart
// R9: Leave burst when feedback stays above restart
// R10: Protections blanked for a period after startup
// R11: Any fault enters auto-restart until removed
// R12: Supply above 39V four cycles is overvoltage
// R13: Supply below 7.0V four cycles is undervoltage
// R14: Valley sense above 3.2V four cycles overvoltage
// R15: Valley current above 2.5mA four cycles line overvoltage
// R16: Valley current below 25uA four cycles line undervoltage
// R17: Valley sense below 0.6V after 4 cycles short
// R18: Sense below 0.1V at 1us shorted resistor
// R19: Sense above 1.75V after blanking open resistor
// R20: No valley within window forces turn-on
// R21: Cycle counters sample once, clear when absent
// R22: Gate low while fault latched or blanking; code still switches the gate during blanking
`ifndef FSQ_CFG_SVH
`define FSQ_CFG_SVH
`define FSQ_CLK_MHZ 50
`define FSQ_SOFT_START_US 1600
`define FSQ_SOFT_START_CYC (`FSQ_SOFT_START_US * `FSQ_CLK_MHZ)
`define FSQ_OVERLOAD_MS 160
`define FSQ_OVERLOAD_CYC (`FSQ_OVERLOAD_MS * 1000 * `FSQ_CLK_MHZ)
`define FSQ_CS_SHORT_NS 1000
`define FSQ_CS_SHORT_CYC ((`FSQ_CS_SHORT_NS * `FSQ_CLK_MHZ + 999) / 1000)
`define FSQ_LEB_NS 300
`define FSQ_LEB_CYC ((`FSQ_LEB_NS * `FSQ_CLK_MHZ + 999) / 1000)
`define FSQ_VALLEY_WIN_NS 3000
`define FSQ_VALLEY_WIN_CYC ((`FSQ_VALLEY_WIN_NS * `FSQ_CLK_MHZ) / 1000)
`define FSQ_QUAL_CYCLES 4
`define FSQ_SHORT_WAIT_CYCLES 4
`define FSQ_BLANK_CYCLES 4
`define FSQ_PERIOD_FULL 667
`define FSQ_PERIOD_MIN 588
`define FSQ_PERIOD_MAX 1724
`define FSQ_RESTART_US 100
`define FSQ_RESTART_CYC (`FSQ_RESTART_US * `FSQ_CLK_MHZ)
`endif

/* File: rtl/fsq_pkg.sv */
package fsq_pkg;
  typedef enum logic [3:0] {
    FSQ_OFF = 4'b0001,
    FSQ_SOFT = 4'b0010,
    FSQ_RUN = 4'b0100,
    FSQ_FAULT = 4'b1000
  } fsq_state_t;
  typedef enum logic [2:0] {
    FSQ_PK_MIN = 3'b001,
    FSQ_PK_MAX = 3'b010,
    FSQ_PK_LAND = 3'b100
  } fsq_peak_t;
endpackage

/* File: rtl/fsq_cycle_qual.sv */
`timescale 1ns/100ps
`include "fsq_cfg.svh"
// Counts consecutive switching cycles with the condition present
module fsq_cycle_qual #(
  parameter int COUNT = `FSQ_QUAL_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sample_i,
  input wire logic cond_i,
  output logic hit_o
);
  logic [3:0] cnt;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt <= 4'h0;
    end else if (sample_i) begin
      if (!cond_i) begin
        cnt <= 4'h0; // R21
      end else if (cnt != 4'(COUNT)) begin
        cnt <= cnt + 4'h1; // R21
      end
    end
  end
  assign hit_o = (cnt == 4'(COUNT));
  property p_clear;
    @(posedge clk_i) disable iff (!nrst_i) (sample_i && !cond_i) |=> !hit_o;
  endproperty
  a_clear: assert property (p_clear) else $error("qualifier not cleared"); // R21
endmodule // fsq_cycle_qual

/* File: rtl/fsq_sequencer.sv */
`timescale 1ns/100ps
`include "fsq_cfg.svh"
module fsq_sequencer #(
  parameter int SOFT_START_CYC = `FSQ_SOFT_START_CYC,
  parameter int OVERLOAD_CYC = `FSQ_OVERLOAD_CYC,
  parameter int RESTART_CYC = `FSQ_RESTART_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic vcc_over_i,
  input wire logic vcc_under_i,
  input wire logic valley_over_i,
  input wire logic valley_short_i,
  input wire logic line_over_i,
  input wire logic line_under_i,
  input wire logic zero_crossing_detect_i,
  input wire logic feedback_max_i,
  input wire logic feedback_stop_level_i,
  input wire logic feedback_restart_level_i,
  input wire logic out_near_target_i,
  input wire logic light_load_i,
  input wire logic [10:0] load_period_i,
  input wire logic cs_short_i,
  input wire logic cs_open_i,
  input wire logic cs_peak_i,
  input wire logic discontinuous_conduction_i,
  output logic gate_o,
  output logic [2:0] peak_level_o,
  output logic burst_o,
  output logic fault_o,
  output logic [6:0] fault_cause_o
);
  localparam int QUAL = `FSQ_QUAL_CYCLES;
  localparam int LEB = `FSQ_LEB_CYC;
  localparam int CSW = `FSQ_CS_SHORT_CYC;
  localparam int VWIN = `FSQ_VALLEY_WIN_CYC;

  function automatic logic [10:0] fold_period(input logic light, input logic [10:0] p);
    logic [10:0] r;
    r = 11'(`FSQ_PERIOD_FULL);
    if (light) begin
      if (p > 11'(`FSQ_PERIOD_MAX)) r = 11'(`FSQ_PERIOD_MAX);
      else if (p < 11'(`FSQ_PERIOD_FULL)) r = 11'(`FSQ_PERIOD_FULL);
      else r = p;
    end
    return r;
  endfunction

  // Two-flop synchronisers on all comparator inputs
  localparam int NS = 18;
  logic [NS-1:0] s1, s2, raw;
  assign raw = {vcc_over_i, vcc_under_i, valley_over_i, valley_short_i, line_over_i,
                line_under_i, zero_crossing_detect_i, feedback_max_i, feedback_stop_level_i,
                feedback_restart_level_i, out_near_target_i, light_load_i, cs_short_i,
                cs_open_i, cs_peak_i, discontinuous_conduction_i, 2'b00};
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  logic vcc_ov, vcc_uv, vd_ov, vd_sh, ln_ov, ln_uv, zero_crossing_detect, fb_max, fb_stop, fb_on;
  logic near_tgt, light, cs_sh, cs_op, cs_pk, discontinuous_conduction;
  assign {vcc_ov, vcc_uv, vd_ov, vd_sh, ln_ov, ln_uv, zero_crossing_detect, fb_max, fb_stop, fb_on,
          near_tgt, light, cs_sh, cs_op, cs_pk, discontinuous_conduction} = s2[NS-1:2];
  logic [10:0] per_s1, per_s2;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      per_s1 <= 11'h0;
      per_s2 <= 11'h0;
    end else begin
      per_s1 <= load_period_i;
      per_s2 <= per_s1;
    end
  end

  fsq_pkg::fsq_state_t state;
  logic [10:0] cyc_cnt;
  logic [6:0] on_cnt;
  logic [7:0] valley_cnt;
  logic [27:0] ovl_cnt;
  logic [23:0] time_cnt;
  logic cycle_end;
  logic [2:0] blank_cnt;
  logic blanking;
  logic [6:0] hits, latched;
  logic [10:0] period;
  logic any_fault;

  // One switching cycle ends at the turn-on edge
  assign period = fold_period(light, per_s2); // R7
  logic turn_on;
  always_comb begin
    turn_on = 1'b0;
    if (!gate_o && cyc_cnt >= period && !burst_o && !any_fault &&
        (state == fsq_pkg::FSQ_SOFT || state == fsq_pkg::FSQ_RUN)) begin
      if (!discontinuous_conduction) turn_on = 1'b1;
      else if (zero_crossing_detect) turn_on = 1'b1; // R6
      else if (valley_cnt >= 8'(VWIN)) turn_on = 1'b1; // R20
    end
  end
  assign cycle_end = turn_on;

  // Cycle-qualified supply and valley-sense checks
  logic [4:0] qcond;
  assign qcond = {vcc_ov, vcc_uv, vd_ov, ln_ov, ln_uv};
  for (genvar g = 0; g < 5; g++) begin : g_qual
    fsq_cycle_qual #(.COUNT(QUAL)) u_qual (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .sample_i(cycle_end),
      .cond_i(qcond[g]),
      .hit_o(hits[g])
    ); // R12 R13 R14 R15 R16
  end

  // Startup blanking counted in switching cycles
  always_ff @(posedge clk_i) begin
    if (!nrst_i || state == fsq_pkg::FSQ_OFF) begin
      blank_cnt <= 3'h0;
    end else if (cycle_end && blank_cnt != 3'(`FSQ_BLANK_CYCLES)) begin
      blank_cnt <= blank_cnt + 3'h1;
    end
  end
  assign blanking = (blank_cnt != 3'(`FSQ_BLANK_CYCLES)); // R10

  assign hits[5] = !blanking && blank_cnt >= 3'(`FSQ_SHORT_WAIT_CYCLES) && vd_sh; // R17
  // Overload timer runs only while feedback sits at its maximum
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !fb_max) begin
      ovl_cnt <= 28'h0;
    end else if (ovl_cnt != 28'(OVERLOAD_CYC)) begin
      ovl_cnt <= ovl_cnt + 28'h1; // R4
    end
  end
  assign hits[6] = (ovl_cnt == 28'(OVERLOAD_CYC)); // R4

  // Turn-on time checks on the sense resistor
  logic cs_fault;
  assign cs_fault = gate_o && ((on_cnt == 7'(CSW) && cs_sh) || (on_cnt >= 7'(LEB) && cs_op));
  always_ff @(posedge clk_i) begin
    if (!nrst_i || state == fsq_pkg::FSQ_OFF) begin
      latched <= 7'h0;
    end else if (state == fsq_pkg::FSQ_FAULT) begin
      latched <= latched;
    end else if (!blanking) begin
      latched <= latched | hits | {6'h0, cs_fault}; // R10 R18 R19
    end
  end
  assign any_fault = |latched;
  assign fault_cause_o = latched;
  assign fault_o = (state == fsq_pkg::FSQ_FAULT);

  logic cond_now;
  assign cond_now = vcc_uv || vcc_ov || fb_max || vd_sh || vd_ov || ln_ov || ln_uv;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= fsq_pkg::FSQ_OFF;
      time_cnt <= 24'h0;
    end else begin
      unique case (state)
        fsq_pkg::FSQ_OFF: begin
          time_cnt <= 24'h0;
          state <= fsq_pkg::FSQ_SOFT;
        end
        fsq_pkg::FSQ_SOFT: begin
          time_cnt <= time_cnt + 24'h1;
          if (any_fault) state <= fsq_pkg::FSQ_FAULT; // R11
          else if (time_cnt == 24'(SOFT_START_CYC - 1)) state <= fsq_pkg::FSQ_RUN; // R2
        end
        fsq_pkg::FSQ_RUN: begin
          time_cnt <= 24'h0;
          if (any_fault) state <= fsq_pkg::FSQ_FAULT; // R1 R11
        end
        fsq_pkg::FSQ_FAULT: begin
          // Hiccup: wait while condition persists, then restart
          if (cond_now) time_cnt <= 24'h0; // R5 R1
          else if (time_cnt == 24'(RESTART_CYC - 1)) state <= fsq_pkg::FSQ_OFF;
          else time_cnt <= time_cnt + 24'h1;
        end
      endcase
    end
  end

  // Burst control with hysteresis
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      burst_o <= 1'b0;
    end else if (fb_stop) begin
      burst_o <= 1'b1; // R8
    end else if (fb_on) begin
      burst_o <= 1'b0; // R8 R9
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      peak_level_o <= fsq_pkg::FSQ_PK_MIN;
    end else if (state == fsq_pkg::FSQ_RUN) begin
      peak_level_o <= near_tgt ? fsq_pkg::FSQ_PK_LAND : fsq_pkg::FSQ_PK_MAX; // R3
    end else begin
      peak_level_o <= fsq_pkg::FSQ_PK_MIN; // R2
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      gate_o <= 1'b0;
      on_cnt <= 7'h0;
      cyc_cnt <= 11'h0;
      valley_cnt <= 8'h0;
    end else begin
      cyc_cnt <= (cyc_cnt == 11'h7ff) ? cyc_cnt : cyc_cnt + 11'h1;
      if (state == fsq_pkg::FSQ_FAULT || state == fsq_pkg::FSQ_OFF || any_fault) begin
        gate_o <= 1'b0; // R22 R1
        on_cnt <= 7'h0;
      end else if (gate_o) begin
        on_cnt <= (on_cnt == 7'h7f) ? on_cnt : on_cnt + 7'h1;
        if ((cs_pk && on_cnt >= 7'(LEB)) || cs_fault) begin
          gate_o <= 1'b0;
          on_cnt <= 7'h0;
        end
      end else if (turn_on) begin
        gate_o <= 1'b1;
        cyc_cnt <= 11'h0;
      end
      if (gate_o || turn_on) valley_cnt <= 8'h0;
      else if (cyc_cnt >= period && valley_cnt != 8'hff) valley_cnt <= valley_cnt + 8'h1;
    end
  end

  property p_fault_gate;
    @(posedge clk_i) disable iff (!nrst_i) (state == fsq_pkg::FSQ_FAULT) |=> !gate_o;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("gate in fault"); // R22
  property p_burst_stop;
    @(posedge clk_i) disable iff (!nrst_i) fb_stop |=> burst_o;
  endproperty
  a_burst_stop: assert property (p_burst_stop) else $error("burst not set"); // R8
  property p_burst_leave;
    @(posedge clk_i) disable iff (!nrst_i) (fb_on && !fb_stop) |=> !burst_o;
  endproperty
  a_burst_leave: assert property (p_burst_leave) else $error("burst not left"); // R9
  property p_soft_min;
    @(posedge clk_i) disable iff (!nrst_i)
      (state == fsq_pkg::FSQ_SOFT) |=> (peak_level_o == fsq_pkg::FSQ_PK_MIN);
  endproperty
  a_soft_min: assert property (p_soft_min) else $error("peak not minimum"); // R2
  property p_land;
    @(posedge clk_i) disable iff (!nrst_i)
      (state == fsq_pkg::FSQ_RUN && near_tgt) |=> (peak_level_o == fsq_pkg::FSQ_PK_LAND);
  endproperty
  a_land: assert property (p_land) else $error("no soft landing"); // R3
  property p_ovl;
    @(posedge clk_i) disable iff (!nrst_i)
      (hits[6] && !blanking && state == fsq_pkg::FSQ_RUN) |=> latched[6];
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload not latched"); // R4
  property p_fault_enter;
    @(posedge clk_i) disable iff (!nrst_i)
      (any_fault && state == fsq_pkg::FSQ_RUN) |=> (state == fsq_pkg::FSQ_FAULT);
  endproperty
  a_fault_enter: assert property (p_fault_enter) else $error("no auto restart"); // R11
  property p_blank;
    @(posedge clk_i) disable iff (!nrst_i)
      (blanking && state != fsq_pkg::FSQ_FAULT && latched == 7'h0) |=> (latched == 7'h0);
  endproperty
  a_blank: assert property (p_blank) else $error("fault during blanking"); // R10
  property p_valley;
    @(posedge clk_i) disable iff (!nrst_i) turn_on |=> gate_o;
  endproperty
  a_valley: assert property (p_valley) else $error("turn-on lost"); // R6
  property p_burst_hold;
    @(posedge clk_i) disable iff (!nrst_i) (burst_o && !gate_o) |=> !gate_o;
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("switching in burst"); // R8
  property p_no_early;
    @(posedge clk_i) disable iff (!nrst_i) (!gate_o && cyc_cnt < period) |=> !gate_o;
  endproperty
  a_no_early: assert property (p_no_early) else $error("turn-on before period"); // R7
  property p_cs_short;
    @(posedge clk_i) disable iff (!nrst_i)
      (gate_o && on_cnt == 7'(CSW) && cs_sh) |=> !gate_o;
  endproperty
  a_cs_short: assert property (p_cs_short) else $error("shorted sense not cut"); // R18
  property p_cs_open;
    @(posedge clk_i) disable iff (!nrst_i)
      (gate_o && on_cnt >= 7'(LEB) && cs_op) |=> !gate_o;
  endproperty
  a_cs_open: assert property (p_cs_open) else $error("open sense not cut"); // R19
  property p_supply_fault;
    @(posedge clk_i) disable iff (!nrst_i)
      (state == fsq_pkg::FSQ_RUN && !blanking && (hits[4] || hits[3])) |-> ##2 fault_o;
  endproperty
  a_supply_fault: assert property (p_supply_fault) else $error("supply fault missed"); // R1 R12 R13
  property p_forced;
    @(posedge clk_i) disable iff (!nrst_i)
      (state == fsq_pkg::FSQ_RUN && discontinuous_conduction && !gate_o && !burst_o && !any_fault &&
       cyc_cnt >= period && valley_cnt >= 8'(VWIN)) |=> gate_o;
  endproperty
  a_forced: assert property (p_forced) else $error("no forced turn-on"); // R20
endmodule // fsq_sequencer

/* File: testbench/fsq_power_stage.sv */
`timescale 1ns/100ps
// Switch, winding and sense: current ramps while on, the winding rings after turn-off
module fsq_power_stage (
  input wire logic clk_i,
  input wire logic gate_i,
  input wire logic mute_i,
  input wire logic sense_short_i,
  output logic zero_crossing_detect_o,
  output logic cs_peak_o
);
  int unsigned on_cnt = 0;
  int unsigned off_cnt = 0;
  always @(posedge clk_i) begin
    on_cnt <= gate_i ? on_cnt + 1 : 0;
    off_cnt <= gate_i ? 0 : off_cnt + 1;
    // Peak comes after leading-edge blanking; a shorted sense resistor never shows it
    cs_peak_o <= gate_i && !sense_short_i && (on_cnt >= 24);
    // Ringing repeats every 32 clocks; each valley is two wide so the synchroniser sees it
    zero_crossing_detect_o <= !mute_i && (off_cnt >= 60) && ((off_cnt % 32) < 2);
  end
endmodule // fsq_power_stage

/* File: testbench/flyback_switch_fault_sequencer_tb_top.sv */
`timescale 1ns/100ps
module flyback_switch_fault_sequencer_tb_top;
  typedef struct {
    logic [8:0] drive;
    logic [6:0] cause;
  } fsq_row_t;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [8:0] flt = 9'h000;
  logic mute = 1'b0;
  logic discontinuous_conduction = 1'b1;
  logic near = 1'b0;
  logic light = 1'b0;
  logic stop = 1'b0;
  logic restart = 1'b1;
  logic [10:0] period = 11'h29b;
  logic zero_crossing_detect, cs_peak, gate_o, burst_o, fault_o, prev_f;
  logic [2:0] peak_level_o;
  logic [6:0] fault_cause_o;
  fsq_row_t rows [9];
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int i;
  int t;
  int n;

  always #10 clk_i = ~clk_i;

  fsq_sequencer #(.SOFT_START_CYC(100), .OVERLOAD_CYC(200), .RESTART_CYC(50)) fsq_sequencer_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .vcc_over_i(flt[0]), .vcc_under_i(flt[1]),
    .valley_over_i(flt[2]), .line_over_i(flt[3]), .line_under_i(flt[4]),
    .valley_short_i(flt[5]), .feedback_max_i(flt[6]), .cs_short_i(flt[7]),
    .cs_open_i(flt[8]), .zero_crossing_detect_i(zero_crossing_detect), .feedback_stop_level_i(stop),
    .feedback_restart_level_i(restart), .out_near_target_i(near), .light_load_i(light),
    .load_period_i(period), .cs_peak_i(cs_peak), .discontinuous_conduction_i(discontinuous_conduction),
    .gate_o(gate_o), .peak_level_o(peak_level_o), .burst_o(burst_o), .fault_o(fault_o),
    .fault_cause_o(fault_cause_o));

  fsq_power_stage fsq_power_stage_i (.clk_i(clk_i), .gate_i(gate_o), .mute_i(mute),
    .sense_short_i(flt[7]), .zero_crossing_detect_o(zero_crossing_detect), .cs_peak_o(cs_peak));

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic do_reset();
    nrst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check({gate_o, burst_o, fault_o, fault_cause_o, peak_level_o} === 13'h001, "reset");
    nrst_i <= 1'b1;
  endtask

  // Clocks from one turn-on to the next
  task automatic gap(output int g);
    g = 0;
    while (gate_o !== 1'b1 && g < 4000) begin
      @(posedge clk_i);
      g++;
    end
    g = 0;
    while (gate_o !== 1'b0 && g < 4000) begin
      @(posedge clk_i);
      g++;
    end
    while (gate_o !== 1'b1 && g < 4000) begin
      @(posedge clk_i);
      g++;
    end
  endtask

  // Gate is registered, so judge it once the fault has stood a cycle
  always @(posedge clk_i) begin
    cyc++;
    prev_f <= fault_o;
    if (prev_f === 1'b1 && fault_o === 1'b1) check(gate_o === 1'b0, "gate in fault");
    if (cyc == 90000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    rows = '{'{9'h001, 7'h10}, '{9'h002, 7'h08}, '{9'h004, 7'h04}, '{9'h008, 7'h02},
      '{9'h010, 7'h01}, '{9'h020, 7'h20}, '{9'h040, 7'h40}, '{9'h080, 7'h01},
      '{9'h100, 7'h01}};
    for (i = 0; i < 9; i++) begin
      do_reset();
      flt <= rows[i].drive;
      repeat (1000) @(posedge clk_i);
      check(fault_o === 1'b0, "fault while blanked");
      t = 0;
      while (fault_o !== 1'b1 && t < 9000) begin
        @(posedge clk_i);
        t++;
      end
      check((fault_cause_o & rows[i].cause) === rows[i].cause, "cause");
      flt <= 9'h000;
      t = 0;
      while (fault_o !== 1'b0 && t < 4000) begin
        @(posedge clk_i);
        t++;
      end
      check(fault_o === 1'b0, "no auto restart");
    end
    do_reset();
    repeat (3) @(posedge clk_i);
    check(peak_level_o === 3'b001, "soft start peak");
    repeat (300) @(posedge clk_i);
    check(peak_level_o === 3'b010, "full drive");
    near <= 1'b1;
    repeat (2000) @(posedge clk_i);
    check(peak_level_o === 3'b100, "soft landing");
    gap(n);
    gap(n);
    check(n >= 667 && n < 817, "valley turn-on period");
    discontinuous_conduction <= 1'b0;
    gap(n);
    check(n >= 667 && n < 680, "fixed period without valleys");
    discontinuous_conduction <= 1'b1;
    mute <= 1'b1;
    gap(n);
    check(n >= 817 && n < 830, "forced turn-on");
    mute <= 1'b0;
    light <= 1'b1;
    period <= 11'h6bc;
    gap(n);
    gap(n);
    check(n >= 1724 && n < 1924, "foldback period");
    restart <= 1'b0;
    stop <= 1'b1;
    repeat (2000) @(posedge clk_i);
    check(burst_o === 1'b1, "burst stop");
    gap(n);
    check(gate_o === 1'b0, "switching in burst");
    stop <= 1'b0;
    restart <= 1'b1;
    repeat (2000) @(posedge clk_i);
    check(burst_o === 1'b0, "burst exit");
    gap(n);
    check(gate_o === 1'b1, "no restart after burst");
    test_done();
  end
endmodule // flyback_switch_fault_sequencer_tb_top
